//--- rtl/modem_cfg_pkg.sv
// Constants for the modem parameter set and its APB register map.
// Assumes a single 20 MHz clock.
package modem_cfg_pkg;
	localparam int unsigned clk_hz = 20000000;
	localparam int unsigned tick_ms = 100;
	localparam int unsigned tick_cycles = (clk_hz / 1000) * tick_ms;
	// Register byte addresses
	localparam logic [7:0] off_rate = 8'h00;
	localparam logic [7:0] off_cca = 8'h04;
	localparam logic [7:0] off_esc = 8'h08;
	localparam logic [7:0] off_role = 8'h0c;
	localparam logic [7:0] off_slot = 8'h10;
	localparam logic [7:0] off_tmo = 8'h14;
	localparam logic [7:0] off_lines = 8'h18;
	localparam logic [7:0] off_ctrl = 8'h1c;
	localparam logic [7:0] off_status = 8'h20;
	localparam logic [7:0] off_active_rate = 8'h24;
	// Reset values and ranges
	localparam logic [16:0] rate_rst = 17'h00003;
	localparam logic [16:0] rate_std_max = 17'h00007;
	localparam logic [16:0] rate_lit_min = 17'h00080;
	localparam logic [16:0] rate_lit_max = 17'h1c200;
	localparam logic [6:0] cca_rst = 7'h2c;
	localparam logic [6:0] cca_max = 7'h50;
	localparam logic [7:0] esc_rst = 8'h2b;
	localparam logic [4:0] slot_rst = 5'h0c;
	localparam logic [4:0] slot_min = 5'h0c;
	localparam logic [4:0] slot_max = 5'h17;
	localparam logic [15:0] tmo_rst = 16'h0064;
	localparam logic [15:0] tmo_min = 16'h0002;
	localparam logic [2:0] code_max = 3'h5;
	localparam logic [2:0] code_off = 3'h0;
	localparam logic [2:0] code_alt = 3'h1;
	localparam logic [2:0] code_adc = 3'h2;
	localparam logic [2:0] code_di = 3'h3;
	localparam logic [2:0] code_lo = 3'h4;
	localparam logic [2:0] code_hi = 3'h5;
	localparam logic [23:0] lines_rst = 24'h208000;
	// Control bits
	localparam int unsigned ctrl_enter = 0;
	localparam int unsigned ctrl_cmd_byte = 1;
	localparam int unsigned ctrl_leave = 2;
	localparam int unsigned ctrl_ack_sent = 3;
	// Rate code table, bits per second
	function automatic logic [16:0] std_rate(input logic [2:0] code);
		unique case (code)
			3'h0: std_rate = 17'd1200;
			3'h1: std_rate = 17'd2400;
			3'h2: std_rate = 17'd4800;
			3'h3: std_rate = 17'd9600;
			3'h4: std_rate = 17'd19200;
			3'h5: std_rate = 17'd38400;
			3'h6: std_rate = 17'd57600;
			3'h7: std_rate = 17'd115200;
		endcase
	endfunction : std_rate
endpackage : modem_cfg_pkg

//--- rtl/rate_quantizer.sv
// Maps a literal bit rate to the nearest rate the clock divider can make.
// Assumes a 20 MHz clock and 16x oversampling; purely combinational.
`timescale 1ns/100ps
`default_nettype none
module rate_quantizer
	import modem_cfg_pkg::*;
(
	// Request
	input wire logic [16:0] rate_in,
	// Result
	output logic [16:0] rate_out,
	output logic [15:0] divisor
);
	localparam int unsigned base = clk_hz / 16;
	logic [31:0] div_w;
	logic [31:0] back_w;

	// Round divisor to nearest, then recompute the rate it really yields
	assign div_w = (rate_in == 17'h0) ? 32'd1 :
		(base + ({15'h0, rate_in} >> 1)) / {15'h0, rate_in};
	assign divisor = (div_w == 32'd0) ? 16'h0001 : div_w[15:0];
	assign back_w = base / {16'h0, divisor};
	assign rate_out = (back_w > 32'h1ffff) ? 17'h1ffff : back_w[16:0];
endmodule : rate_quantizer
`default_nettype wire

//--- rtl/idle_timer.sv
// Command-mode inactivity timer in 100 ms ticks.
// Assumes restart pulses on any command activity; run low holds it clear.
`timescale 1ns/100ps
`default_nettype none
module idle_timer
	import modem_cfg_pkg::*;
#(
	parameter int unsigned tick_len = tick_cycles
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Control
	input wire logic run,
	input wire logic restart,
	input wire logic [15:0] limit,
	// Result
	output logic expired
);
	logic [31:0] pre;
	logic [15:0] ticks;
	logic tick;

	assign tick = (pre == tick_len - 1);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pre <= 32'h0;
			ticks <= 16'h0;
			expired <= 1'b0;
		end else if (!run || restart) begin
			pre <= 32'h0;
			ticks <= 16'h0;
			expired <= 1'b0;
		end else begin
			pre <= tick ? 32'h0 : pre + 32'h1;
			if (tick) begin
				ticks <= ticks + 16'h1;
			end
			expired <= tick && (ticks + 16'h1 >= limit);
		end
	end
endmodule : idle_timer
`default_nettype wire

//--- rtl/modem_host_param_config.sv
// Parameter set and command-mode control of a serial radio modem, APB slave.
// Assumes the serial byte parser outside reports bytes and guard events.
// Contract
// - rate codes 0-7 pick standard rates, default 3
// - values above seven are literal, quantised rates
// - literal 0x80-0x1C200 accepted, stored value reads back
// - new rate active after exit acknowledged
// - suppress transmit when energy exceeds threshold
// - guard, escape character, guard enters command mode
// - command-mode bytes are commands, not payload
// - role 0 end device, 1 coordinator
// - channel 0x0C to 0x17, default 0x0C
// - explicit exit command leaves command mode
// - leave command mode after idle timeout
// - lines zero to four take codes 0-5
// - sixth line code 1 is association blink
// - seventh line code 1 RTS, 2 unsupported
// - eighth line code 1 CTS, 2 unsupported
`timescale 1ns/100ps
`default_nettype none
module modem_host_param_config
	import modem_cfg_pkg::*;
#(
	parameter int unsigned tick_len = tick_cycles
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial side events
	input wire logic [7:0] host_byte,
	input wire logic host_byte_valid,
	input wire logic guard_before,
	input wire logic guard_after,
	// Radio side
	input wire logic [6:0] energy_level,
	input wire logic tx_request,
	input wire logic associated,
	input wire logic blink,
	output logic tx_grant,
	output logic tx_suppressed,
	// Host interface settings in force
	output logic [15:0] host_divisor,
	output logic command_mode,
	output logic payload_valid,
	output logic [7:0] payload_byte,
	output logic coordinator,
	output logic [4:0] radio_frequency_slot,
	// General I/O lines
	output logic [7:0] line_out,
	output logic [7:0] line_oe,
	output logic [7:0] line_adc_en,
	output logic rts_flow_en,
	output logic cts_flow_en
);
	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {idle_mode, escape_seen, cmd_mode} mode_t;
	mode_t mode;
	logic [16:0] host_rate_code;
	logic [16:0] pending_rate;
	logic [6:0] clear_assessment_level;
	logic [7:0] escape_character;
	logic role;
	logic [15:0] command_idle_timeout;
	logic [23:0] line_cfg;
	logic exit_pending;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire wr_go = psel && penable && pwrite;
	wire rd_go = psel && penable && !pwrite;
	wire [16:0] wr_rate = pwdata[16:0];
	wire rate_std = wr_rate <= rate_std_max;
	wire rate_lit = (wr_rate >= rate_lit_min) && (wr_rate <= rate_lit_max);
	wire rate_ok = rate_std || rate_lit;
	wire cca_ok = pwdata[6:0] <= cca_max && pwdata[31:7] == 25'h0;
	wire role_ok = pwdata[31:1] == 31'h0;
	wire slot_ok = pwdata[4:0] >= slot_min && pwdata[4:0] <= slot_max
		&& pwdata[31:5] == 27'h0;
	wire tmo_ok = pwdata[15:0] >= tmo_min && pwdata[31:16] == 16'h0;
	wire esc_ok = pwdata[31:8] == 24'h0;

	function automatic logic code_ok(input logic [2:0] c, input logic no_alt_2);
		code_ok = (c <= code_max) && !(no_alt_2 && c == code_adc);
	endfunction : code_ok

	logic lines_ok;
	always_comb begin
		lines_ok = pwdata[31:24] == 8'h0;
		for (int i = 0; i < 8; i++) begin
			lines_ok = lines_ok && code_ok(pwdata[3*i +: 3], i >= 6);
		end
	end

	wire sel_rate = paddr == off_rate;
	wire sel_cca = paddr == off_cca;
	wire sel_esc = paddr == off_esc;
	wire sel_role = paddr == off_role;
	wire sel_slot = paddr == off_slot;
	wire sel_tmo = paddr == off_tmo;
	wire sel_lines = paddr == off_lines;
	wire sel_ctrl = paddr == off_ctrl;
	wire sel_status = paddr == off_status;
	wire sel_active = paddr == off_active_rate;
	wire mapped = sel_rate | sel_cca | sel_esc | sel_role | sel_slot | sel_tmo
		| sel_lines | sel_ctrl | sel_status | sel_active;
	wire wr_bad = (sel_rate && !rate_ok) || (sel_cca && !cca_ok)
		|| (sel_esc && !esc_ok) || (sel_role && !role_ok)
		|| (sel_slot && !slot_ok) || (sel_tmo && !tmo_ok)
		|| (sel_lines && !lines_ok) || sel_status || sel_active;
	wire err = !mapped || (pwrite && wr_bad);
	wire wr_ok = wr_go && !err;

	////////////////////////////////////////////////////////////////////////////
	// Literal rate quantisation
	logic [16:0] lit_stored;
	logic [15:0] lit_div;
	logic [15:0] std_div;
	logic [16:0] active_bps;

	rate_quantizer u_lit (
		.rate_in(wr_rate),
		.rate_out(lit_stored),
		.divisor()
	);
	rate_quantizer u_active (
		.rate_in(active_bps),
		.rate_out(),
		.divisor(lit_div)
	);
	assign std_div = lit_div;
	assign active_bps = (pending_rate <= rate_std_max) ?
		std_rate(pending_rate[2:0]) : pending_rate;

	////////////////////////////////////////////////////////////////////////////
	// Command mode sequencing
	logic timed_out;
	wire cmd_activity = (mode == cmd_mode) && (host_byte_valid || wr_ok);
	wire leave_cmd = wr_ok && sel_ctrl && pwdata[ctrl_leave];
	wire ack_sent = wr_go && sel_ctrl && pwdata[ctrl_ack_sent];
	wire esc_hit = host_byte_valid && host_byte == escape_character && guard_before;

	idle_timer #(
		.tick_len(tick_len)
	) u_timer (
		.mclk(mclk),
		.rstn(rstn),
		.run(mode == cmd_mode),
		.restart(cmd_activity),
		.limit(command_idle_timeout),
		.expired(timed_out)
	);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mode <= idle_mode;
			exit_pending <= 1'b0;
		end else begin
			// Clear first so a leave in the same write still sets it
			if (ack_sent) begin
				exit_pending <= 1'b0;
			end
			unique case (mode)
				idle_mode: if (esc_hit) begin
					mode <= escape_seen;
				end
				escape_seen: begin
					if (guard_after) begin
						mode <= cmd_mode;
					end else if (host_byte_valid) begin
						mode <= idle_mode;
					end
				end
				cmd_mode: begin
					if (leave_cmd) begin
						mode <= idle_mode;
						exit_pending <= 1'b1;
					end else if (timed_out) begin
						mode <= idle_mode;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Parameter storage
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			host_rate_code <= rate_rst;
			pending_rate <= rate_rst;
			clear_assessment_level <= cca_rst;
			escape_character <= esc_rst;
			role <= 1'b0;
			radio_frequency_slot <= slot_rst;
			command_idle_timeout <= tmo_rst;
			line_cfg <= lines_rst;
		end else begin
			if (wr_ok && sel_rate) begin
				host_rate_code <= rate_std ? wr_rate : lit_stored;
			end
			if (wr_ok && sel_cca) begin
				clear_assessment_level <= pwdata[6:0];
			end
			if (wr_ok && sel_esc) begin
				escape_character <= pwdata[7:0];
			end
			if (wr_ok && sel_role) begin
				role <= pwdata[0];
			end
			if (wr_ok && sel_slot) begin
				radio_frequency_slot <= pwdata[4:0];
			end
			if (wr_ok && sel_tmo) begin
				command_idle_timeout <= pwdata[15:0];
			end
			if (wr_ok && sel_lines) begin
				line_cfg <= pwdata[23:0];
			end
			if (exit_pending && ack_sent) begin
				pending_rate <= host_rate_code;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux
	wire [31:0] rd_mux =
		sel_rate ? {15'h0, host_rate_code} :
		sel_cca ? {25'h0, clear_assessment_level} :
		sel_esc ? {24'h0, escape_character} :
		sel_role ? {31'h0, role} :
		sel_slot ? {27'h0, radio_frequency_slot} :
		sel_tmo ? {16'h0, command_idle_timeout} :
		sel_lines ? {8'h0, line_cfg} :
		sel_status ? {28'h0, exit_pending, tx_suppressed, mode} :
		sel_active ? {15'h0, pending_rate} : 32'h0;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && err;
			prdata <= (psel && !penable && !pwrite && !err) ? rd_mux : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Datapath outputs
	logic [7:0] next_out;
	logic [7:0] next_oe;
	logic [7:0] next_adc;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			next_out[i] = line_cfg[3*i +: 3] == code_hi;
			next_oe[i] = line_cfg[3*i +: 3] == code_lo || line_cfg[3*i +: 3] == code_hi;
			next_adc[i] = line_cfg[3*i +: 3] == code_adc;
		end
		if (line_cfg[17:15] == code_alt) begin
			next_out[5] = associated && blink;
			next_oe[5] = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			line_out <= 8'h0;
			line_oe <= 8'h0;
			line_adc_en <= 8'h0;
			rts_flow_en <= 1'b0;
			cts_flow_en <= 1'b0;
			tx_grant <= 1'b0;
			tx_suppressed <= 1'b0;
			host_divisor <= 16'h0;
			command_mode <= 1'b0;
			payload_valid <= 1'b0;
			payload_byte <= 8'h0;
			coordinator <= 1'b0;
		end else begin
			line_out <= next_out;
			line_oe <= next_oe;
			line_adc_en <= next_adc;
			rts_flow_en <= line_cfg[20:18] == code_alt;
			cts_flow_en <= line_cfg[23:21] == code_alt;
			tx_grant <= tx_request && energy_level <= clear_assessment_level;
			tx_suppressed <= tx_request && energy_level > clear_assessment_level;
			host_divisor <= std_div;
			command_mode <= mode == cmd_mode;
			payload_valid <= host_byte_valid && mode != cmd_mode && !esc_hit;
			payload_byte <= host_byte;
			coordinator <= role;
		end
	end
endmodule : modem_host_param_config
`default_nettype wire

//--- tb/host_cfg_sva.sv
// Port assertions for the parameter block.
// Assumes it is bound to the block's top module.
`timescale 1ns/100ps
`default_nettype none
module host_cfg_sva (
	// Watched ports
	input wire logic mclk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] host_byte,
	input wire logic host_byte_valid,
	input wire logic tx_request,
	input wire logic tx_grant,
	input wire logic tx_suppressed,
	input wire logic command_mode,
	input wire logic payload_valid,
	input wire logic [7:0] payload_byte,
	input wire logic [4:0] radio_frequency_slot
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_in_access: assert property (pready |-> psel && penable && !$past(penable))
		else $error("ready outside access");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready too long");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_tx_answered: assert property (tx_request |=> tx_grant || tx_suppressed)
		else $error("transmit request unanswered");
	a_grant_cause: assert property (tx_grant |-> $past(tx_request))
		else $error("grant without request");
	a_cmd_no_payload: assert property (command_mode |-> !payload_valid)
		else $error("payload in command mode");
	a_payload_echo: assert property (payload_valid |-> $past(host_byte_valid)
		&& payload_byte == $past(host_byte))
		else $error("payload not host byte");
	a_slot_range: assert property (radio_frequency_slot inside {[5'h0c:5'h17]})
		else $error("channel out of range");
endmodule : host_cfg_sva
bind modem_host_param_config host_cfg_sva i_sva (.mclk, .rstn, .psel, .penable, .pready,
	.pslverr, .host_byte, .host_byte_valid, .tx_request, .tx_grant, .tx_suppressed,
	.command_mode, .payload_valid, .payload_byte, .radio_frequency_slot);
`default_nettype wire

//--- tb/host_serial_model.sv
// Host on the serial side: sends bytes and escape sequences.
// Assumes guard interval detection upstream reports guard events.
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
	// Clock
	input wire logic mclk,
	// Byte events
	output logic [7:0] host_byte,
	output logic host_byte_valid,
	output logic guard_before,
	output logic guard_after
);
	initial begin
		host_byte = 8'h00;
		host_byte_valid = 1'b0;
		guard_before = 1'b0;
		guard_after = 1'b0;
	end
	// One byte per call, paced well below the radio rate
	task send(input logic [7:0] b, input logic gap);
		@(posedge mclk);
		host_byte <= b;
		host_byte_valid <= 1'b1;
		guard_before <= gap;
		@(posedge mclk);
		host_byte <= ~b;
		host_byte_valid <= 1'b0;
		guard_before <= 1'b0;
	endtask : send
	// Guard, escape character, guard
	task escape(input logic [7:0] c);
		send(c, 1'b1);
		repeat (3) @(posedge mclk);
		guard_after <= 1'b1;
		@(posedge mclk);
		guard_after <= 1'b0;
	endtask : escape
endmodule : host_serial_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the modem parameter block.
// Assumes the checker and host model compile first.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic mclk, rstn, psel, penable, pwrite, tx_request, associated, blink;
	logic [7:0] paddr;
	logic [31:0] pwdata, rq;
	logic [6:0] energy_level;
	logic re;
	wire [31:0] prdata;
	wire pready, pslverr, host_byte_valid, guard_before, guard_after, tx_grant;
	wire tx_suppressed, command_mode, payload_valid, coordinator, rts_flow_en, cts_flow_en;
	wire [7:0] host_byte, payload_byte, line_out, line_oe, line_adc_en;
	wire [15:0] host_divisor;
	wire [4:0] radio_frequency_slot;
	int failures = 0;
	int num_checks = 0;
	// Divisor per standard rate code: 1.25 MHz over the rate, rounded
	logic [31:0] divs [8] = '{32'd1042, 32'd521, 32'd260, 32'd130, 32'd65, 32'd33,
		32'd22, 32'd11};
	// Address, error, data written, value read back
	logic [75:0] tv [17] = '{76'h04_1_00000051_0000002c, 76'h04_0_00000050_00000050,
		76'h10_1_0000000b_0000000c, 76'h10_1_00000018_0000000c, 76'h10_0_00000017_00000017,
		76'h14_1_00000001_00000064, 76'h14_0_00000002_00000002, 76'h0c_1_00000002_00000000,
		76'h0c_0_00000001_00000001, 76'h00_1_0000007f_00000003, 76'h00_1_0001c201_00000003,
		76'h00_0_0000012c_0000012b, 76'h00_0_0001c200_0001bbe4, 76'h18_1_00041006_00208000,
		76'h18_1_00088000_00208000, 76'h18_1_00408000_00208000, 76'h18_0_006480a5_006480a5};
	modem_host_param_config #(.tick_len(20)) i_dut (.mclk, .rstn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .host_byte, .host_byte_valid,
		.guard_before, .guard_after, .energy_level, .tx_request, .associated, .blink,
		.tx_grant, .tx_suppressed, .host_divisor, .command_mode, .payload_valid,
		.payload_byte, .coordinator, .radio_frequency_slot, .line_out, .line_oe,
		.line_adc_en, .rts_flow_en, .cts_flow_en);
	host_serial_model i_host (.mclk, .host_byte, .host_byte_valid, .guard_before,
		.guard_after);
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////
	task complete_run;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task check(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			complete_run();
		end
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		check("pslverr", {31'h0, e}, {31'h0, re});
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check("prdata", e, rq);
	endtask : rd
	task wait_mode(input logic v, input int lim, output int n);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (command_mode !== v && n < lim);
		if (n >= lim) begin
			failures++;
			complete_run();
		end
	endtask : wait_mode
	////////////////////////////////////////////////////////////////
	task t_defaults;
		logic [7:0] da [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h24};
		logic [31:0] dv [8] = '{32'h3, 32'h2c, 32'h2b, 32'h0, 32'hc, 32'h64, 32'h208000, 32'h3};
		for (int i = 0; i < 8; i++)
			rd(da[i], dv[i]);
		check("divisor", 32'd130, {16'h0, host_divisor});
		check("flow", 32'h1, {30'h0, rts_flow_en, cts_flow_en});
	endtask : t_defaults
	task t_ranges;
		for (int i = 0; i < 17; i++) begin
			wr(tv[i][75:68], tv[i][63:32], tv[i][64]);
			rd(tv[i][75:68], tv[i][31:0]);
		end
		wr(8'h20, 32'h0, 1'b1);
		wr(8'h28, 32'h0, 1'b1);
		check("role slot", 32'h37, {26'h0, coordinator, radio_frequency_slot});
		check("lines", 32'h3e, {25'h0, line_out[1:0], line_oe[1:0], line_adc_en[2], rts_flow_en,
			cts_flow_en});
		check("assoc dark", 32'h2, {30'h0, line_oe[5], line_out[5]});
		blink <= 1'b1;
		repeat (2) @(posedge mclk);
		check("assoc lit", 32'h3, {30'h0, line_oe[5], line_out[5]});
	endtask : t_ranges
	task t_rates;
		int n;
		logic [31:0] prev;
		prev = 32'h3;
		for (int c = 0; c < 8; c++) begin
			i_host.escape(8'h2b);
			wait_mode(1'b1, 10, n);
			i_host.send(8'h41, 1'b0);
			@(posedge mclk);
			check("payload in command", 32'h0, {31'h0, payload_valid});
			wr(8'h00, c, 1'b0);
			wr(8'h1c, 32'h4, 1'b0);
			repeat (2) @(posedge mclk);
			check("mode", 32'h0, {31'h0, command_mode});
			rd(8'h24, prev);
			check("divisor held", divs[prev[2:0]], {16'h0, host_divisor});
			wr(8'h1c, 32'h8, 1'b0);
			rd(8'h24, c);
			check("divisor", divs[c], {16'h0, host_divisor});
			prev = c;
		end
	endtask : t_rates
	task t_cca;
		logic [6:0] lv [3] = '{7'h00, 7'h20, 7'h21};
		wr(8'h04, 32'h20, 1'b0);
		for (int i = 0; i < 3; i++) begin
			@(posedge mclk);
			energy_level <= lv[i];
			tx_request <= 1'b1;
			@(posedge mclk);
			tx_request <= 1'b0;
			@(posedge mclk);
			check("grant", {31'h0, lv[i] <= 7'h20}, {31'h0, tx_grant});
			check("suppressed", {31'h0, lv[i] > 7'h20}, {31'h0, tx_suppressed});
		end
	endtask : t_cca
	task t_payload;
		i_host.send(8'h5a, 1'b0);
		@(posedge mclk);
		check("payload", 32'h15a, {23'h0, payload_valid, payload_byte});
	endtask : t_payload
	task t_idle;
		int n;
		i_host.escape(8'h2b);
		wait_mode(1'b1, 10, n);
		wait_mode(1'b0, 200, n);
		check("idle exit", 32'h1, {31'h0, n >= 36 && n <= 46});
	endtask : t_idle
	////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		{psel, penable, pwrite, tx_request, associated, blink} = 6'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		energy_level = 7'h00;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		associated <= 1'b1;
		t_defaults();
		t_ranges();
		t_rates();
		t_cca();
		t_payload();
		t_idle();
		complete_run();
	end
	initial begin
		repeat (100000) @(posedge mclk);
		failures++;
		complete_run();
	end
endmodule : tb
`default_nettype wire
